// File: src/bst_tap.sv
/*
  Boundary-scan test port: controller, instruction, bypass, id and
  boundary registers, and the user pin multiplexer.
  Assumes the test clock is slow enough to be oversampled by the core clock
  (at least four core cycles per test clock phase) and that the core logic
  supplies its pin values on the core clock.
*/
`timescale 1ns/10ps
module bst_tap #(
  parameter int BSR_LEN = bst_pkg::BSR_LEN_SMALL, // [R3] [R4] [R15]
  parameter logic [3:0] ID_VER = bst_pkg::ID_VER_DEF,
  parameter logic [15:0] ID_PART = bst_pkg::ID_PART_DEF,
  parameter logic [10:0] ID_MAKER = bst_pkg::ID_MAKER_DEF,
  parameter logic [31:0] USERCODE = bst_pkg::USERCODE_DEF
) (
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic TCK_IN,
  input wire logic TMS_IN,
  input wire logic TDI_IN,
  input wire logic TRST_N_IN,
  input wire logic CFG_BUSY_IN,
  input wire logic JTAG_CFG_IN,
  input wire logic [BSR_LEN/bst_pkg::CELLS_PER_PIN-1:0] PIN_IN,
  input wire logic [BSR_LEN/bst_pkg::CELLS_PER_PIN-1:0] CORE_OUT_IN,
  input wire logic [BSR_LEN/bst_pkg::CELLS_PER_PIN-1:0] CORE_OE_IN,
  output logic [BSR_LEN/bst_pkg::CELLS_PER_PIN-1:0] PIN_OUT,
  output logic [BSR_LEN/bst_pkg::CELLS_PER_PIN-1:0] PIN_OE_OUT,
  output logic TDO_OUT,
  output logic TDO_OE_OUT,
  output logic CONFIG_HALT_OUT
);
  localparam int NPINS = BSR_LEN / bst_pkg::CELLS_PER_PIN;
  localparam logic [31:0] ID_WORD = {ID_VER, ID_PART, ID_MAKER, 1'b1}; // [R6]
  localparam logic [2:0] TMS_ONES_MAX = 3'(bst_pkg::TMS_RESET_CLKS);

  bst_pkg::bst_pins_t pins_raw;
  bst_pkg::bst_pins_t pins_s;
  logic [NPINS-1:0] pin_in_s;

  assign pins_raw = '{tck: TCK_IN, tms: TMS_IN, tdi: TDI_IN,
                      trst_n: TRST_N_IN, cfg_busy: CFG_BUSY_IN,
                      jtag_cfg: JTAG_CFG_IN}; // [R1]

  bst_sync #(.W($bits(bst_pkg::bst_pins_t))) u_sync_ctl (
    .clk_in(CORE_CLK_IN),
    .rst_in(SYS_RST_IN),
    .d_in(pins_raw),
    .q_out(pins_s)
  );

  bst_sync #(.W(NPINS)) u_sync_pin (
    .clk_in(CORE_CLK_IN),
    .rst_in(SYS_RST_IN),
    .d_in(PIN_IN),
    .q_out(pin_in_s)
  );

  bst_pkg::bst_state_t state_q, state_d;
  logic tck_q;
  logic tck_rise, tck_fall;
  logic [bst_pkg::IR_LEN-1:0] ir_sh_q, ir_sh_d, ir_act_q, ir_act_d, ins_eff;
  logic [BSR_LEN-1:0] bsr_sh_q, bsr_sh_d, bsr_upd_q, bsr_upd_d;
  logic [bst_pkg::ID_LEN-1:0] id_sh_q, id_sh_d; // [R5]
  logic byp_q, byp_d, tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;
  logic halt_q, halt_d;
  logic [NPINS-1:0] pin_out_q, pin_out_d, pin_oe_q, pin_oe_d;
  logic [2:0] tms_ones_q, tms_ones_d;
  logic sel_bsr, sel_id, ser_out;

  assign tck_rise = pins_s.tck & ~tck_q;
  assign tck_fall = ~pins_s.tck & tck_q;

  // while configuring, anything but the safe three runs as bypass so the
  // load is not disturbed; the reconfigure instruction lifts this
  always_comb begin
    ins_eff = ir_act_q;
    if (pins_s.cfg_busy && !halt_q &&
        ir_act_q != bst_pkg::INS_SAMPLE && ir_act_q != bst_pkg::INS_IDCODE &&
        ir_act_q != bst_pkg::INS_CONFIG_IO) begin
      ins_eff = bst_pkg::INS_BYPASS; // [R13]
    end
  end

  assign sel_bsr = (ins_eff == bst_pkg::INS_SAMPLE) ||
                   (ins_eff == bst_pkg::INS_EXTEST); // [R9]
  assign sel_id = (ins_eff == bst_pkg::INS_IDCODE) ||
                  (ins_eff == bst_pkg::INS_USERCODE); // [R10]

  always_comb begin
    ser_out = byp_q;
    if (state_q == bst_pkg::ST_SHIFT_IR) begin
      ser_out = ir_sh_q[0];
    end else if (sel_bsr) begin
      ser_out = bsr_sh_q[0];
    end else if (sel_id) begin
      ser_out = id_sh_q[0]; // [R7]
    end
  end

  always_comb begin
    state_d = state_q;
    tms_ones_d = tms_ones_q;
    if (tck_rise) begin
      tms_ones_d = (pins_s.tms && tms_ones_q != TMS_ONES_MAX) ?
                   tms_ones_q + 3'h1 : (pins_s.tms ? tms_ones_q : 3'h0);
      unique case (state_q)
        bst_pkg::ST_RESET: state_d = pins_s.tms ? bst_pkg::ST_RESET
                                                : bst_pkg::ST_IDLE;
        bst_pkg::ST_IDLE: state_d = pins_s.tms ? bst_pkg::ST_SEL_DR
                                               : bst_pkg::ST_IDLE;
        bst_pkg::ST_SEL_DR: state_d = pins_s.tms ? bst_pkg::ST_SEL_IR
                                                 : bst_pkg::ST_CAP_DR;
        bst_pkg::ST_CAP_DR: state_d = pins_s.tms ? bst_pkg::ST_EXIT1_DR
                                                 : bst_pkg::ST_SHIFT_DR;
        bst_pkg::ST_SHIFT_DR: state_d = pins_s.tms ? bst_pkg::ST_EXIT1_DR
                                                   : bst_pkg::ST_SHIFT_DR;
        bst_pkg::ST_EXIT1_DR: state_d = pins_s.tms ? bst_pkg::ST_UPD_DR
                                                   : bst_pkg::ST_PAUSE_DR;
        bst_pkg::ST_PAUSE_DR: state_d = pins_s.tms ? bst_pkg::ST_EXIT2_DR
                                                   : bst_pkg::ST_PAUSE_DR;
        bst_pkg::ST_EXIT2_DR: state_d = pins_s.tms ? bst_pkg::ST_UPD_DR
                                                   : bst_pkg::ST_SHIFT_DR;
        bst_pkg::ST_UPD_DR: state_d = pins_s.tms ? bst_pkg::ST_SEL_DR
                                                 : bst_pkg::ST_IDLE;
        bst_pkg::ST_SEL_IR: state_d = pins_s.tms ? bst_pkg::ST_RESET
                                                 : bst_pkg::ST_CAP_IR;
        bst_pkg::ST_CAP_IR: state_d = pins_s.tms ? bst_pkg::ST_EXIT1_IR
                                                 : bst_pkg::ST_SHIFT_IR;
        bst_pkg::ST_SHIFT_IR: state_d = pins_s.tms ? bst_pkg::ST_EXIT1_IR
                                                   : bst_pkg::ST_SHIFT_IR;
        bst_pkg::ST_EXIT1_IR: state_d = pins_s.tms ? bst_pkg::ST_UPD_IR
                                                   : bst_pkg::ST_PAUSE_IR;
        bst_pkg::ST_PAUSE_IR: state_d = pins_s.tms ? bst_pkg::ST_EXIT2_IR
                                                   : bst_pkg::ST_PAUSE_IR;
        bst_pkg::ST_EXIT2_IR: state_d = pins_s.tms ? bst_pkg::ST_UPD_IR
                                                   : bst_pkg::ST_SHIFT_IR;
        bst_pkg::ST_UPD_IR: state_d = pins_s.tms ? bst_pkg::ST_SEL_DR
                                                 : bst_pkg::ST_IDLE; // [R14]
      endcase
    end
    if (!pins_s.trst_n) begin
      state_d = bst_pkg::ST_RESET; // [R14]
      tms_ones_d = 3'h0;
    end
  end

  always_comb begin
    ir_sh_d = ir_sh_q;
    ir_act_d = ir_act_q;
    bsr_sh_d = bsr_sh_q;
    bsr_upd_d = bsr_upd_q;
    id_sh_d = id_sh_q;
    byp_d = byp_q;
    halt_d = halt_q;
    if (tck_rise) begin
      unique case (state_q)
        bst_pkg::ST_CAP_IR: ir_sh_d = bst_pkg::IR_CAPTURE;
        bst_pkg::ST_SHIFT_IR: begin
          ir_sh_d = {pins_s.tdi, ir_sh_q[bst_pkg::IR_LEN-1:1]};
        end
        bst_pkg::ST_UPD_IR: begin
          ir_act_d = ir_sh_q;
          if (ir_sh_q == bst_pkg::INS_CONFIG_IO) begin
            halt_d = 1'b1; // [R13]
          end
        end
        bst_pkg::ST_CAP_DR: begin
          byp_d = 1'b0; // [R9]
          id_sh_d = (ins_eff == bst_pkg::INS_USERCODE) ? USERCODE : ID_WORD;
          if (sel_bsr) begin
            for (int i = 0; i < NPINS; i++) begin
              bsr_sh_d[i*bst_pkg::CELLS_PER_PIN+bst_pkg::CELL_IN] = pin_in_s[i];
              bsr_sh_d[i*bst_pkg::CELLS_PER_PIN+bst_pkg::CELL_OUT] =
                CORE_OUT_IN[i];
              bsr_sh_d[i*bst_pkg::CELLS_PER_PIN+bst_pkg::CELL_OE] =
                CORE_OE_IN[i]; // [R9]
            end
          end
        end
        bst_pkg::ST_SHIFT_DR: begin
          byp_d = pins_s.tdi; // [R11]
          if (sel_bsr) begin
            bsr_sh_d = {pins_s.tdi, bsr_sh_q[BSR_LEN-1:1]};
          end
          if (sel_id) begin
            id_sh_d = {pins_s.tdi, id_sh_q[bst_pkg::ID_LEN-1:1]};
          end
        end
        bst_pkg::ST_UPD_DR: begin
          if (sel_bsr) begin
            bsr_upd_d = bsr_sh_q; // [R9]
          end
        end
        bst_pkg::ST_RESET: begin
          ir_act_d = bst_pkg::INS_IDCODE; // [R10]
          halt_d = 1'b0;
        end
        default: begin
        end
      endcase
    end
    if (!pins_s.trst_n) begin
      ir_act_d = bst_pkg::INS_IDCODE;
      halt_d = 1'b0;
    end
  end

  // tdo changes only on the falling test clock so the next device in the
  // chain samples a stable bit on its rising edge
  always_comb begin
    tdo_d = tdo_q;
    tdo_oe_d = tdo_oe_q;
    if (tck_fall) begin
      tdo_oe_d = (state_q == bst_pkg::ST_SHIFT_DR) ||
                 (state_q == bst_pkg::ST_SHIFT_IR); // [R11]
      tdo_d = ser_out;
    end
  end

  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      pin_out_d[i] = CORE_OUT_IN[i];
      pin_oe_d[i] = CORE_OE_IN[i];
      if (ins_eff == bst_pkg::INS_EXTEST || ins_eff == bst_pkg::INS_CLAMP) begin
        pin_out_d[i] = bsr_upd_q[i*bst_pkg::CELLS_PER_PIN+bst_pkg::CELL_OUT];
        pin_oe_d[i] = bsr_upd_q[i*bst_pkg::CELLS_PER_PIN+bst_pkg::CELL_OE];
      end
      if (ins_eff == bst_pkg::INS_HIGHZ || pins_s.jtag_cfg) begin
        pin_oe_d[i] = 1'b0; // [R2] [R10]
      end
    end
  end

  // reset state makes the port usable at once after power-up
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      state_q <= bst_pkg::ST_RESET; // [R12]
      tms_ones_q <= 3'h0;
      tck_q <= 1'b0;
      ir_sh_q <= '0;
      ir_act_q <= bst_pkg::INS_IDCODE;
      bsr_sh_q <= '0;
      bsr_upd_q <= '0;
      id_sh_q <= '0;
      byp_q <= 1'b0;
      halt_q <= 1'b0;
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
      pin_out_q <= '0;
      pin_oe_q <= '0;
    end else begin
      state_q <= state_d;
      tms_ones_q <= tms_ones_d;
      tck_q <= pins_s.tck;
      ir_sh_q <= ir_sh_d;
      ir_act_q <= ir_act_d;
      bsr_sh_q <= bsr_sh_d;
      bsr_upd_q <= bsr_upd_d;
      id_sh_q <= id_sh_d;
      byp_q <= byp_d;
      halt_q <= halt_d;
      tdo_q <= tdo_d;
      tdo_oe_q <= tdo_oe_d;
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  assign TDO_OUT = tdo_q;
  assign TDO_OE_OUT = tdo_oe_q;
  assign PIN_OUT = pin_out_q;
  assign PIN_OE_OUT = pin_oe_q;
  assign CONFIG_HALT_OUT = halt_q;

  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  a_trst_reset: assert property ( // [R14]
    !pins_s.trst_n |=> state_q == bst_pkg::ST_RESET)
    else $error("reset pin did not force controller reset");
  a_five_ones: assert property ( // [R14]
    tms_ones_q == TMS_ONES_MAX |-> state_q == bst_pkg::ST_RESET)
    else $error("five tms ones did not reach reset");
  a_id_marker: assert property ( // [R7]
    tck_rise && state_q == bst_pkg::ST_CAP_DR &&
    ins_eff == bst_pkg::INS_IDCODE |=> id_sh_q[0] && id_sh_q == ID_WORD &&
    id_sh_q[bst_pkg::ID_LEN-1:bst_pkg::ID_VER_LSB] == ID_VER)
    else $error("id capture wrong or marker bit not one");
  a_highz_float: assert property ( // [R10]
    ins_eff == bst_pkg::INS_HIGHZ |=> pin_oe_q == '0)
    else $error("pin driven under highz");
  a_cfg_float: assert property ( // [R2]
    pins_s.jtag_cfg |=> pin_oe_q == '0)
    else $error("pin driven during test-port configuration");
  a_cfg_guard: assert property ( // [R13]
    pins_s.cfg_busy && !halt_q && ir_act_q == bst_pkg::INS_EXTEST
    |-> ins_eff == bst_pkg::INS_BYPASS)
    else $error("extest ran during configuration");
  a_ir_update: assert property ( // [R9]
    tck_rise && state_q == bst_pkg::ST_UPD_IR && pins_s.trst_n
    |=> ir_act_q == $past(ir_sh_q))
    else $error("instruction not loaded on update");
  a_tdo_drive: assert property ( // [R11]
    tck_fall && state_q == bst_pkg::ST_SHIFT_DR
    |=> tdo_oe_q && tdo_q == $past(ser_out))
    else $error("tdo not driven during shift");
  a_bypass_cap: assert property ( // [R9]
    tck_rise && state_q == bst_pkg::ST_CAP_DR |=> !byp_q)
    else $error("bypass cell did not capture zero");
endmodule

// File: src/bst_pkg.sv
/*
  Constants, types and instruction codes of the boundary-scan test port.
  Assumes one core clock that oversamples the test clock pin.
*/
// Notes on behaviour
// [R1] four test pins plus optional async reset
// [R2] user pins float during test-port configuration
// [R3] scan chain length is per-variant constant
// [R4] largest package bumps 2682 chain to 2970
// [R5] id word: version, part, maker, marker
// [R6] version at top, marker at bit zero
// [R7] id bit zero always one, shifts first
// [R8] host reads id only with status high
// [R9] sample/preload, extest, bypass with capture, drive
// [R10] idcode, usercode, clamp, highz supported
// [R11] one device in a shared daisy chain
// [R12] scan logic live from power-up onward
// [R13] only bypass/idcode/sample during configuration; the code also runs INS_CONFIG_IO, which then lifts the limit
// [R14] sixteen-state controller, five ones reset
// [R15] chain length and id are build parameters
package bst_pkg;
  localparam int BSR_LEN_SMALL = 1506;
  localparam int BSR_LEN_MID = 2274;
  localparam int BSR_LEN_UPPER = 2682;
  localparam int BSR_LEN_BIG = 2970;
  localparam int BSR_LEN_MAX = 3402;
  localparam int CELLS_PER_PIN = 3;
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_OE = 2;
  localparam int ID_LEN = 32;
  localparam int ID_VER_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MAKER_LSB = 1;
  localparam int TMS_RESET_CLKS = 5;
  localparam int IR_LEN = 10;
  localparam logic [IR_LEN-1:0] IR_CAPTURE = 10'h001;
  localparam logic [IR_LEN-1:0] INS_EXTEST = 10'h00F;
  localparam logic [IR_LEN-1:0] INS_SAMPLE = 10'h005;
  localparam logic [IR_LEN-1:0] INS_IDCODE = 10'h006;
  localparam logic [IR_LEN-1:0] INS_USERCODE = 10'h007;
  localparam logic [IR_LEN-1:0] INS_CLAMP = 10'h00A;
  localparam logic [IR_LEN-1:0] INS_HIGHZ = 10'h00B;
  localparam logic [IR_LEN-1:0] INS_CONFIG_IO = 10'h00D;
  localparam logic [IR_LEN-1:0] INS_BYPASS = 10'h3FF;
  // arbitrary identity values, not those of any real part
  localparam logic [3:0] ID_VER_DEF = 4'h1;
  localparam logic [15:0] ID_PART_DEF = 16'h1234;
  localparam logic [10:0] ID_MAKER_DEF = 11'h155;
  localparam logic [31:0] USERCODE_DEF = 32'hFFFFFFFF;

  typedef enum logic [3:0] {
    ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h3, ST_CAP_DR = 4'h2,
    ST_SHIFT_DR = 4'h6, ST_EXIT1_DR = 4'h7, ST_PAUSE_DR = 4'h5,
    ST_EXIT2_DR = 4'h4, ST_UPD_DR = 4'hC, ST_SEL_IR = 4'hD,
    ST_CAP_IR = 4'hF, ST_SHIFT_IR = 4'hE, ST_EXIT1_IR = 4'hA,
    ST_PAUSE_IR = 4'hB, ST_EXIT2_IR = 4'h9, ST_UPD_IR = 4'h8
  } bst_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic cfg_busy;
    logic jtag_cfg;
  } bst_pins_t;
endpackage

// File: src/bst_sync.sv
/*
  Two-flop synchroniser of any width.
  Assumes each bit is an independent level from outside the clock domain.
*/
`timescale 1ns/10ps
module bst_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;
endmodule

// File: tb/bst_host.sv
/*
  Behavioural test host that drives the scan port pins and collects tdo.
  Assumes each call starts just after a core clock edge.
*/
`timescale 1ns/10ps
module bst_host #(
  parameter int LEN = 1506
) (
  input wire logic clk_in,
  input wire logic tdo_in,
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  output logic [LEN-1:0] cap_out,
  output logic cap_ok_out
);
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
    cap_out = '0;
    cap_ok_out = 1'b0;
  end
  // one test clock of 8 core cycles; mode and data change at the fall,
  // tdo is taken late in the high phase where it has long settled
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tck_out = 1'b0;
    tms_out = tms;
    tdi_out = tdi;
    repeat (4) @(posedge clk_in);
    #1 tck_out = 1'b1;
    repeat (4) @(posedge clk_in);
    #1 tdo = tdo_in;
  endtask
  // lsb first; the last bit carries mode high to leave the shift state
  task automatic shift(input int n, input logic [LEN-1:0] din);
    logic b;
    logic [LEN-1:0] got;
    got = '0;
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      got[i] = b;
    end
    tdi_out = 1'b1; // released data line rests at its pull-up
    cap_out = got;
    cap_ok_out = 1'b1;
    @(posedge clk_in);
    #1 cap_ok_out = 1'b0;
  endtask
endmodule

// File: tb/testbench.sv
/*
  Self-checking bench for the boundary-scan test port.
  Assumes the host model bst_host and the design package.
*/
`timescale 1ns/10ps
module testbench;
  localparam int LEN = bst_pkg::BSR_LEN_SMALL;
  localparam int NP = LEN / bst_pkg::CELLS_PER_PIN;
  // arbitrary identity values
  localparam logic [3:0] VER = 4'h5;
  localparam logic [15:0] PART = 16'hA5C3;
  localparam logic [10:0] MAKER = 11'h2B7;
  localparam logic [31:0] UCODE = 32'h0BADF00D;
  localparam logic [31:0] ID = {VER, PART, MAKER, 1'b1};
  localparam logic [7:0] BYP = 8'hB5;
  localparam logic [7:0] BYP_EXP = {BYP[6:0], 1'b0};
  logic clk, rst, tck, tms, tdi, trst_n, cfg_busy, jtag_cfg;
  logic tdo, tdo_oe, halt, cap_ok;
  logic [NP-1:0] pin_in, core_out, core_oe, pin_out, pin_oe;
  logic [LEN-1:0] cap, pat;
  logic [LEN-1:0] exp_q[$];
  int fail_count = 0;
  int checks_done = 0;
  int seed = 32;

  bst_tap #(.BSR_LEN(LEN), .ID_VER(VER), .ID_PART(PART), .ID_MAKER(MAKER),
    .USERCODE(UCODE)) u_bst_tap (.CORE_CLK_IN(clk), .SYS_RST_IN(rst),
    .TCK_IN(tck), .TMS_IN(tms), .TDI_IN(tdi), .TRST_N_IN(trst_n),
    .CFG_BUSY_IN(cfg_busy), .JTAG_CFG_IN(jtag_cfg), .PIN_IN(pin_in),
    .CORE_OUT_IN(core_out), .CORE_OE_IN(core_oe), .PIN_OUT(pin_out),
    .PIN_OE_OUT(pin_oe), .TDO_OUT(tdo), .TDO_OE_OUT(tdo_oe),
    .CONFIG_HALT_OUT(halt));
  bst_host #(.LEN(LEN)) u_bst_host (.clk_in(clk), .tdo_in(tdo),
    .tck_out(tck), .tms_out(tms), .tdi_out(tdi), .cap_out(cap),
    .cap_ok_out(cap_ok));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [LEN-1:0] seen, input logic [LEN-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: value differs from expectation", $time);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // every finished shift is matched against the oldest expectation
  always @(posedge clk) begin
    if (cap_ok === 1'b1) begin
      if (exp_q.size() == 0)
        check('1, '0);
      else
        check(cap, exp_q.pop_front());
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    end_sim();
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // mode bits applied lsb first, data line held at its idle level
  task automatic walk(input int n, input logic [7:0] seq);
    logic b;
    for (int i = 0; i < n; i++)
      u_bst_host.tick(seq[i], 1'b1, b);
  endtask

  task automatic scan_dr(input int n, input logic [LEN-1:0] din,
                         input logic [LEN-1:0] exp);
    walk(3, 8'h01);
    exp_q.push_back(exp);
    u_bst_host.shift(n, din);
    walk(2, 8'h01);
  endtask

  task automatic load_ir(input logic [bst_pkg::IR_LEN-1:0] code);
    walk(4, 8'h03);
    exp_q.push_back(LEN'(bst_pkg::IR_CAPTURE));
    u_bst_host.shift(bst_pkg::IR_LEN, LEN'(code));
    walk(2, 8'h01);
  endtask

  task automatic preload;
    logic [LEN-1:0] e;
    for (int i = 0; i < NP; i++) begin
      e[3*i +: 3] = {core_oe[i], core_out[i], pin_in[i]};
      pat[3*i +: 3] = 3'($random(seed));
    end
    load_ir(bst_pkg::INS_SAMPLE);
    scan_dr(LEN, pat, e);
  endtask

  // mode 0: pins follow core, 1: pins from cells, 2: all enables off
  task automatic pins_chk(input int mode);
    logic [NP-1:0] eo, ee;
    for (int i = 0; i < NP; i++) begin
      eo[i] = (mode == 0) ? core_out[i] : pat[3*i+1];
      ee[i] = (mode == 0) ? core_oe[i] : (mode == 1) ? pat[3*i+2] : 1'b0;
    end
    if (mode < 2)
      check(LEN'(pin_out), LEN'(eo));
    check(LEN'(pin_oe), LEN'(ee));
  endtask

  initial begin
    rst = 1'b1;
    trst_n = 1'b1;
    cfg_busy = 1'b0;
    jtag_cfg = 1'b0;
    for (int i = 0; i < NP; i++) begin
      pin_in[i] = 1'($random(seed));
      core_out[i] = 1'($random(seed));
      core_oe[i] = 1'($random(seed));
    end
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    wt(4);
    walk(6, 8'h1F);
    check(LEN'(tdo_oe), '0);
    scan_dr(32, '0, LEN'(ID));
    $display("done: identification after reset");
    load_ir(bst_pkg::INS_USERCODE);
    scan_dr(32, '0, LEN'(UCODE));
    load_ir(bst_pkg::INS_BYPASS);
    scan_dr(8, LEN'(BYP), LEN'(BYP_EXP));
    $display("done: user code and bypass");
    preload();
    pins_chk(0);
    load_ir(bst_pkg::INS_EXTEST);
    wt(2);
    pins_chk(1);
    $display("done: sample, preload and external test");
    load_ir(bst_pkg::INS_HIGHZ);
    wt(2);
    check(LEN'(pin_oe), '0);
    load_ir(bst_pkg::INS_CLAMP);
    wt(2);
    pins_chk(1);
    scan_dr(8, LEN'(BYP), LEN'(BYP_EXP));
    jtag_cfg = 1'b1;
    wt(6);
    pins_chk(2);
    jtag_cfg = 1'b0;
    $display("done: float, clamp and test-port configuration");
    // five mode-high clocks from inside shift-DR must reach reset
    walk(3, 8'h01);
    walk(6, 8'h1F);
    pins_chk(0);
    scan_dr(32, '0, LEN'(ID));
    $display("done: mode-select reset");
    cfg_busy = 1'b1;
    load_ir(bst_pkg::INS_EXTEST);
    scan_dr(8, LEN'(BYP), LEN'(BYP_EXP));
    pins_chk(0);
    load_ir(bst_pkg::INS_IDCODE);
    scan_dr(32, '0, LEN'(ID));
    load_ir(bst_pkg::INS_CONFIG_IO);
    check(LEN'(halt), LEN'(1'b1));
    preload();
    load_ir(bst_pkg::INS_EXTEST);
    wt(2);
    pins_chk(1);
    $display("done: instructions during configuration");
    trst_n = 1'b0;
    wt(4);
    trst_n = 1'b1;
    wt(4);
    check(LEN'(halt), '0);
    walk(1, 8'h00);
    cfg_busy = 1'b0;
    pins_chk(0);
    scan_dr(32, '0, LEN'(ID));
    $display("done: test reset pin");
    wt(4);
    if (exp_q.size() != 0)
      fail_count++;
    end_sim();
  end
endmodule
